// *** src/sdpi_pkg.sv ***
// constants and command codes shared by both ends of the sdram pin interface
// ----------------------------------------------------------------------------
// Notes on behaviour
// R1: device registers every input on rising edge
// R2: bursts and outputs advance on clock edges
// R3: clock gate low: power-down or suspend
// R4: clock gate acts asynchronously inside power-down
// R5: power-down freezes input capture except clock gate
// R6: chip select low enables command decoding
// R7: commands coded by select and three strobes
// R8: masked write lanes leave memory unchanged
// R9: read mask floats lane two clocks later
// R10: bank inputs target each bank command
// R11: activate captures thirteen bit row address
// R12: column from bits 0-9,11; bit 10 autoprecharge
// R13: precharge all when bit 10 high
// R14: load mode takes opcode from address
// R15: each mask bit governs one byte lane
// R16: controller may hold clock gate high
// ----------------------------------------------------------------------------
package sdpi_pkg;
    localparam int LANES = 5;
    localparam int LANE_W = 8;
    localparam int DQ_W = LANES * LANE_W;
    localparam int ADDR_W = 13;
    localparam int BA_W = 2;
    localparam int BANKS = 4;
    localparam int COL_W = 11;
    localparam int CMD_W = 4;
    // command code {select, row strobe, column strobe, write enable}, active low
    localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
    localparam logic [3:0] CMD_REFRESH = 4'h1;
    localparam logic [3:0] CMD_PRECHARGE = 4'h2;
    localparam logic [3:0] CMD_ACTIVATE = 4'h3;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_BURST_STOP = 4'h6;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_INHIBIT = 4'hF;
    // address bit roles
    localparam int AP_BIT = 10;
    localparam int COL_HI_BIT = 11;
    localparam int COL_LO_W = 10;
    // mode opcode fields
    localparam int BL_LSB = 0;
    localparam int BL_W = 3;
    localparam int CL_LSB = 4;
    localparam int CL_W = 3;
    localparam logic [2:0] BL_ONE = 3'h0;
    localparam logic [2:0] BL_TWO = 3'h1;
    localparam logic [2:0] BL_FOUR = 3'h2;
    localparam logic [2:0] BL_EIGHT = 3'h3;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [2:0] CL_THREE = 3'h3;
    localparam logic [12:0] MODE_RST = 13'h0023;
    // wrap masks for burst column counting
    localparam logic [10:0] MASK_ONE = 11'h000;
    localparam logic [10:0] MASK_TWO = 11'h001;
    localparam logic [10:0] MASK_FOUR = 11'h003;
    localparam logic [10:0] MASK_EIGHT = 11'h007;
    localparam logic [10:0] MASK_PAGE = 11'h7FF;
    localparam logic [10:0] LEFT_LAST = 11'h001;
    // reduced storage kept by the device end
    localparam int ROW_KEEP = 2;
    localparam int COL_KEEP = 4;
    localparam int MEM_AW = BA_W + ROW_KEEP + COL_KEEP;
    localparam int MEM_DEPTH = 1 << MEM_AW;
    // power state codes on the status output
    localparam logic [1:0] PWR_RUN = 2'h0;
    localparam logic [1:0] PWR_PRE_PD = 2'h1;
    localparam logic [1:0] PWR_ACT_PD = 2'h2;
    localparam logic [1:0] PWR_SUSPEND = 2'h3;
endpackage

// *** src/sdpi_if.sv ***
// pin bundle between memory controller and sdram device
`timescale 1ns/10ps
`default_nettype none
interface sdpi_if;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [sdpi_pkg::BA_W-1:0] ba;
    logic [sdpi_pkg::ADDR_W-1:0] addr;
    logic [sdpi_pkg::LANES-1:0] dqm;
    logic [sdpi_pkg::DQ_W-1:0] dq_ctl;
    logic [sdpi_pkg::LANES-1:0] dq_ctl_oe;
    logic [sdpi_pkg::DQ_W-1:0] dq_dev;
    logic [sdpi_pkg::LANES-1:0] dq_dev_oe;
    logic [sdpi_pkg::DQ_W-1:0] dq;

    // ------------------------------------------------------------------------
    // lane resolution, undriven lanes read zero
    // ------------------------------------------------------------------------
    genvar g;
    for (g = 0; g < sdpi_pkg::LANES; g++)
    begin : g_lane
        assign dq[g*sdpi_pkg::LANE_W +: sdpi_pkg::LANE_W] =
            dq_dev_oe[g] ? dq_dev[g*sdpi_pkg::LANE_W +: sdpi_pkg::LANE_W] :
            dq_ctl_oe[g] ? dq_ctl[g*sdpi_pkg::LANE_W +: sdpi_pkg::LANE_W] :
            {sdpi_pkg::LANE_W{1'b0}};
    end

    modport ctrl (
        output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_ctl, dq_ctl_oe,
        input dq, dq_dev_oe
    );
    modport dev (
        input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
        output dq_dev, dq_dev_oe
    );
endinterface
`default_nettype wire

// *** src/sdpi_ctrl.sv ***
// memory controller end: registers user requests onto the pins
`timescale 1ns/10ps
`default_nettype none
module sdpi_ctrl (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    sdpi_if.ctrl pins,
    input wire logic cke_i,
    input wire logic cmd_valid_i,
    input wire logic [sdpi_pkg::CMD_W-1:0] cmd_i,
    input wire logic [sdpi_pkg::BA_W-1:0] ba_i,
    input wire logic [sdpi_pkg::ADDR_W-1:0] addr_i,
    input wire logic [sdpi_pkg::DQ_W-1:0] wdata_i,
    input wire logic wdata_en_i,
    input wire logic [sdpi_pkg::LANES-1:0] mask_i,
    output logic [sdpi_pkg::DQ_W-1:0] rdata_o,
    output logic rvalid_o
);
    // ------------------------------------------------------------------------
    // command and address pins
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pins.cke <= 1'b0;
            {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= sdpi_pkg::CMD_INHIBIT;
            pins.ba <= '0;
            pins.addr <= '0;
        end
        else
        begin
            pins.cke <= cke_i; // [R3] [R16]
            if (cmd_valid_i)
            begin
                {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= cmd_i; // [R7]
            end
            else
            begin
                {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= sdpi_pkg::CMD_NOP;
            end
            pins.ba <= ba_i; // [R10]
            pins.addr <= addr_i; // [R14]
        end
    end

    // ------------------------------------------------------------------------
    // data and mask pins
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pins.dqm <= '0;
            pins.dq_ctl <= '0;
            pins.dq_ctl_oe <= '0;
        end
        else
        begin
            pins.dqm <= mask_i;
            pins.dq_ctl <= wdata_i;
            pins.dq_ctl_oe <= {sdpi_pkg::LANES{wdata_en_i}};
        end
    end

    // ------------------------------------------------------------------------
    // read capture
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rdata_o <= '0;
            rvalid_o <= 1'b0;
        end
        else
        begin
            rdata_o <= pins.dq;
            rvalid_o <= |pins.dq_dev_oe;
        end
    end
endmodule // sdpi_ctrl
`default_nettype wire

// *** src/sdpi_device.sv ***
// sdram device end: command decode, bank state, burst engine, byte lanes
`timescale 1ns/10ps
`default_nettype none
module sdpi_device (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    sdpi_if.dev pins,
    output logic [sdpi_pkg::ADDR_W-1:0] mode_o,
    output logic [1:0] pwr_state_o,
    output logic [sdpi_pkg::BANKS-1:0] bank_open_o,
    output logic burst_active_o
);
    typedef enum logic [1:0] {ST_RUN, ST_PRE_PD, ST_ACT_PD, ST_SUSP} sdpi_pwr_t;

    sdpi_pwr_t pwr;
    sdpi_pwr_t next_pwr;
    logic cke_r;
    logic cs_n_r;
    logic ras_n_r;
    logic cas_n_r;
    logic we_n_r;
    logic [sdpi_pkg::BA_W-1:0] ba_r;
    logic [sdpi_pkg::ADDR_W-1:0] addr_r;
    logic [sdpi_pkg::LANES-1:0] dqm_r;
    logic [sdpi_pkg::LANES-1:0] dqm_r2;
    logic [sdpi_pkg::DQ_W-1:0] dq_r;
    logic [sdpi_pkg::ADDR_W-1:0] row [sdpi_pkg::BANKS];
    logic [sdpi_pkg::DQ_W-1:0] mem [sdpi_pkg::MEM_DEPTH];
    logic [3:0] cmd;
    logic act;
    logic cmd_ok;
    logic start;
    logic bst_act;
    logic bst_wr;
    logic bst_ap;
    logic bst_full;
    logic [sdpi_pkg::BA_W-1:0] bst_bank;
    logic [sdpi_pkg::COL_W-1:0] bst_col;
    logic [sdpi_pkg::COL_W-1:0] bst_mask;
    logic [sdpi_pkg::COL_W-1:0] bst_left;
    logic [sdpi_pkg::COL_W-1:0] start_mask;
    logic [sdpi_pkg::COL_W-1:0] acc_col;
    logic [sdpi_pkg::COL_W-1:0] acc_mask;
    logic [sdpi_pkg::COL_W-1:0] next_col;
    logic [sdpi_pkg::BA_W-1:0] acc_bank;
    logic acc;
    logic acc_wr;
    logic acc_ap;
    logic last;
    logic stop;
    logic ap_close;
    logic [sdpi_pkg::BA_W-1:0] ap_bank;
    logic [sdpi_pkg::MEM_AW-1:0] idx;
    logic [sdpi_pkg::DQ_W-1:0] rd_d1;
    logic [sdpi_pkg::DQ_W-1:0] rd_d2;
    logic rd_v1;
    logic rd_v2;
    logic cl_three;

    // ------------------------------------------------------------------------
    // input capture
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cke_r <= 1'b0;
            {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= sdpi_pkg::CMD_INHIBIT;
            ba_r <= '0;
            addr_r <= '0;
            dqm_r <= '0;
            dqm_r2 <= '0;
            dq_r <= '0;
        end
        else
        begin
            cke_r <= pins.cke; // [R1]
            if (pwr == ST_PRE_PD || pwr == ST_ACT_PD)
            begin
                cs_n_r <= 1'b1; // [R5]
            end
            else
            begin
                {cs_n_r, ras_n_r, cas_n_r, we_n_r} <=
                    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n}; // [R1]
                ba_r <= pins.ba;
                addr_r <= pins.addr;
                dqm_r <= pins.dqm;
                dq_r <= pins.dq;
                dqm_r2 <= dqm_r;
            end
        end
    end

    // ------------------------------------------------------------------------
    // power state
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_pwr = pwr;
        case (pwr)
            ST_RUN:
            begin
                if (!cke_r)
                begin
                    if (bst_act)
                        next_pwr = ST_SUSP; // [R3]
                    else if (|bank_open_o)
                        next_pwr = ST_ACT_PD; // [R3]
                    else
                        next_pwr = ST_PRE_PD; // [R3]
                end
            end
            ST_SUSP:
            begin
                if (cke_r)
                    next_pwr = ST_RUN;
            end
            ST_PRE_PD, ST_ACT_PD:
            begin
                // exit follows the pin itself, not the captured copy
                if (pins.cke)
                    next_pwr = ST_RUN; // [R4]
            end
            default:
            begin
                next_pwr = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pwr <= ST_RUN;
            pwr_state_o <= sdpi_pkg::PWR_RUN;
        end
        else
        begin
            pwr <= next_pwr;
            case (next_pwr)
                ST_PRE_PD: pwr_state_o <= sdpi_pkg::PWR_PRE_PD;
                ST_ACT_PD: pwr_state_o <= sdpi_pkg::PWR_ACT_PD;
                ST_SUSP: pwr_state_o <= sdpi_pkg::PWR_SUSPEND;
                default: pwr_state_o <= sdpi_pkg::PWR_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------------
    assign cmd = {cs_n_r, ras_n_r, cas_n_r, we_n_r}; // [R7]
    assign act = cke_r && (pwr == ST_RUN || pwr == ST_SUSP); // [R2]
    assign cmd_ok = act && !cs_n_r; // [R6]
    assign start = cmd_ok && (cmd == sdpi_pkg::CMD_READ || cmd == sdpi_pkg::CMD_WRITE);
    assign stop = cmd_ok && (cmd == sdpi_pkg::CMD_BURST_STOP ||
        (cmd == sdpi_pkg::CMD_PRECHARGE && (addr_r[sdpi_pkg::AP_BIT] || ba_r == bst_bank)));

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            mode_o <= sdpi_pkg::MODE_RST;
        else if (cmd_ok && cmd == sdpi_pkg::CMD_LOAD_MODE)
            mode_o <= addr_r; // [R14]
    end

    // ------------------------------------------------------------------------
    // bank rows
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            bank_open_o <= '0;
            for (int b = 0; b < sdpi_pkg::BANKS; b++)
                row[b] <= '0;
        end
        else
        begin
            if (ap_close)
                bank_open_o[ap_bank] <= 1'b0;
            if (cmd_ok && cmd == sdpi_pkg::CMD_ACTIVATE)
            begin
                bank_open_o[ba_r] <= 1'b1; // [R10]
                row[ba_r] <= addr_r; // [R11]
            end
            if (cmd_ok && cmd == sdpi_pkg::CMD_PRECHARGE)
            begin
                if (addr_r[sdpi_pkg::AP_BIT])
                    bank_open_o <= '0; // [R13]
                else
                    bank_open_o[ba_r] <= 1'b0; // [R13] [R10]
            end
        end
    end

    // ------------------------------------------------------------------------
    // burst engine
    // ------------------------------------------------------------------------
    always_comb
    begin
        case (mode_o[sdpi_pkg::BL_LSB +: sdpi_pkg::BL_W])
            sdpi_pkg::BL_ONE: start_mask = sdpi_pkg::MASK_ONE;
            sdpi_pkg::BL_TWO: start_mask = sdpi_pkg::MASK_TWO;
            sdpi_pkg::BL_FOUR: start_mask = sdpi_pkg::MASK_FOUR;
            sdpi_pkg::BL_EIGHT: start_mask = sdpi_pkg::MASK_EIGHT;
            default: start_mask = sdpi_pkg::MASK_PAGE;
        endcase
    end

    assign acc = act && (start || bst_act);
    assign acc_col = start ? {addr_r[sdpi_pkg::COL_HI_BIT],
        addr_r[sdpi_pkg::COL_LO_W-1:0]} : bst_col; // [R12]
    assign acc_bank = start ? ba_r : bst_bank; // [R10]
    assign acc_wr = start ? (cmd == sdpi_pkg::CMD_WRITE) : bst_wr;
    assign acc_ap = start ? addr_r[sdpi_pkg::AP_BIT] : bst_ap; // [R12]
    assign acc_mask = start ? start_mask : bst_mask;
    assign last = start ? (start_mask == sdpi_pkg::MASK_ONE) :
        (!bst_full && bst_left == sdpi_pkg::LEFT_LAST);
    // sequential order, wrapping inside the burst
    assign next_col = (acc_col & ~acc_mask) | ((acc_col + 11'h001) & acc_mask);

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            bst_act <= 1'b0;
            bst_wr <= 1'b0;
            bst_ap <= 1'b0;
            bst_full <= 1'b0;
            bst_bank <= '0;
            bst_col <= '0;
            bst_mask <= '0;
            bst_left <= '0;
            ap_close <= 1'b0;
            ap_bank <= '0;
        end
        else
        begin
            ap_close <= acc && acc_ap && last;
            ap_bank <= acc_bank;
            if (start)
            begin
                bst_act <= !last;
                bst_wr <= acc_wr;
                bst_ap <= acc_ap;
                bst_full <= (mode_o[sdpi_pkg::BL_LSB +: sdpi_pkg::BL_W] == sdpi_pkg::BL_FULL);
                bst_bank <= acc_bank;
                bst_mask <= start_mask;
                bst_left <= start_mask;
                bst_col <= next_col;
            end
            else if (stop)
            begin
                bst_act <= 1'b0;
            end
            else if (acc)
            begin
                bst_act <= !last; // [R2]
                bst_left <= bst_left - 11'h001;
                bst_col <= next_col;
            end
        end
    end

    assign burst_active_o = bst_act;

    // ------------------------------------------------------------------------
    // storage and byte lanes
    // ------------------------------------------------------------------------
    assign idx = {acc_bank, row[acc_bank][sdpi_pkg::ROW_KEEP-1:0],
        acc_col[sdpi_pkg::COL_KEEP-1:0]};

    always_ff @(posedge core_clk_i)
    begin
        if (acc && acc_wr)
        begin
            for (int l = 0; l < sdpi_pkg::LANES; l++)
            begin
                if (!dqm_r[l]) // [R8] [R15]
                    mem[idx][l*sdpi_pkg::LANE_W +: sdpi_pkg::LANE_W] <=
                        dq_r[l*sdpi_pkg::LANE_W +: sdpi_pkg::LANE_W];
            end
        end
    end

    assign cl_three = (mode_o[sdpi_pkg::CL_LSB +: sdpi_pkg::CL_W] == sdpi_pkg::CL_THREE);

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rd_d1 <= '0;
            rd_d2 <= '0;
            rd_v1 <= 1'b0;
            rd_v2 <= 1'b0;
            pins.dq_dev <= '0;
            pins.dq_dev_oe <= '0;
        end
        else if (pwr == ST_PRE_PD || pwr == ST_ACT_PD)
        begin
            pins.dq_dev_oe <= '0;
        end
        else if (act)
        begin
            rd_d1 <= mem[idx];
            rd_v1 <= acc && !acc_wr;
            rd_d2 <= rd_d1;
            rd_v2 <= rd_v1;
            pins.dq_dev <= cl_three ? rd_d2 : rd_d1; // [R2]
            pins.dq_dev_oe <= {sdpi_pkg::LANES{cl_three ? rd_v2 : rd_v1}}
                & ~dqm_r2; // [R9] [R15]
        end
    end
endmodule // sdpi_device
`default_nettype wire

// *** tb/sdpi_sva.sv ***
// concurrent checks on the pin bundle between controller and device
`timescale 1ns/10ps
`default_nettype none
module sdpi_sva (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [sdpi_pkg::ADDR_W-1:0] addr,
    input wire logic [sdpi_pkg::LANES-1:0] dqm,
    input wire logic [sdpi_pkg::LANES-1:0] dq_ctl_oe,
    input wire logic [sdpi_pkg::LANES-1:0] dq_dev_oe
);
    logic [3:0] cmd;
    assign cmd = {cs_n, ras_n, cas_n, we_n};

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);

    // ------------------------------------------------------------------------
    // command sequences
    // ------------------------------------------------------------------------
    sequence s_nop;
        cke && cmd == sdpi_pkg::CMD_NOP && dqm == '0;
    endsequence
    sequence s_read;
        cke ##1 cke && cmd == sdpi_pkg::CMD_READ && dqm == '0;
    endsequence
    sequence s_quiet_write;
        (cke && cmd == sdpi_pkg::CMD_NOP && dq_dev_oe == '0)[*4]
            ##1 (cke && cmd == sdpi_pkg::CMD_WRITE);
    endsequence

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    a_reset_idle_pins: assert property ($rose(rstn_i) |-> cs_n && !cke && dq_dev_oe == '0)
        else $error("pins not idle after reset");
    a_mask_lane_float: assert property (cke[*5] |-> (dq_dev_oe & $past(dqm, 3)) == '0)
        else $error("masked read lane still driven");
    a_read_drives_lanes: assert property (s_read ##1 s_nop[*2] |-> ##[1:2] dq_dev_oe == '1)
        else $error("read data not driven after latency");
    a_deselect_quiet: assert property
        ((cke && cs_n && dqm == '0 && dq_dev_oe == '0)[*6] |=> dq_dev_oe == '0)
        else $error("device drives while deselected");
    a_gate_freeze_out: assert property (!cke[*4] |-> $stable(dq_dev_oe))
        else $error("outputs move while clock gated");
    a_write_no_drive: assert property (s_quiet_write |=> (dq_dev_oe == '0)[*3])
        else $error("device drives during write");
    a_pre_all_stop: assert property
        (cke && cmd == sdpi_pkg::CMD_PRECHARGE && addr[sdpi_pkg::AP_BIT] ##1 s_nop[*5]
            |=> dq_dev_oe == '0)
        else $error("burst survives precharge all");
    a_lane_one_driver: assert property ((dq_ctl_oe & dq_dev_oe) == '0)
        else $error("both ends drive one lane");
endmodule // sdpi_sva
`default_nettype wire

// *** tb/tb_sdram_pin_command_interface.sv ***
// self-checking bench joining controller and device ends
`timescale 1ns/10ps
`default_nettype none
module tb_sdram_pin_command_interface;
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic cke_i = 1'b1;
    logic cmd_valid_i = 1'b0;
    logic [3:0] cmd_i = 4'h7;
    logic [1:0] ba_i = 2'h0;
    logic [12:0] addr_i = 13'h0000;
    logic [39:0] wdata_i = 40'h0;
    logic wdata_en_i = 1'b0;
    logic [4:0] mask_i = 5'h00;
    logic [39:0] rdata_o;
    logic rvalid_o;
    logic [12:0] mode_o;
    logic [1:0] pwr_state_o;
    logic [3:0] bank_open_o;
    logic burst_active_o;
    int n_mismatch = 0;
    int total_checks = 0;
    logic [39:0] mem [int];
    int open_row [4];
    int nb;
    logic [39:0] d;
    int seed;

    sdpi_if bus ();
    sdpi_ctrl sdpi_ctrl_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .pins(bus), .cke_i(cke_i),
        .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .ba_i(ba_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wdata_en_i(wdata_en_i), .mask_i(mask_i), .rdata_o(rdata_o),
        .rvalid_o(rvalid_o));
    sdpi_device sdpi_device_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .pins(bus),
        .mode_o(mode_o), .pwr_state_o(pwr_state_o), .bank_open_o(bank_open_o),
        .burst_active_o(burst_active_o));
    sdpi_sva sdpi_sva_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .cke(bus.cke),
        .cs_n(bus.cs_n), .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n),
        .addr(bus.addr), .dqm(bus.dqm), .dq_ctl_oe(bus.dq_ctl_oe), .dq_dev_oe(bus.dq_dev_oe));

    always #4 core_clk_i = ~core_clk_i;

    // ------------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------------
    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    task automatic issue(input logic [3:0] c, input int b, input int a, input logic [4:0] m);
        @(posedge core_clk_i);
        cmd_valid_i <= 1'b1;
        cmd_i <= c;
        ba_i <= 2'(b);
        addr_i <= 13'(a);
        mask_i <= m;
        wdata_i <= d;
        wdata_en_i <= (c == sdpi_pkg::CMD_WRITE);
        @(posedge core_clk_i);
        cmd_valid_i <= 1'b0;
        mask_i <= 5'h00;
        wdata_en_i <= 1'b0;
    endtask

    function automatic int key(input int b, input int col);
        return (b << 6) | ((open_row[b] & 3) << 4) | (col & 15);
    endfunction

    task automatic wr(input int b, input int col, input logic [4:0] m);
        logic [39:0] cur;
        cur = mem.exists(key(b, col)) ? mem[key(b, col)] : 40'h0;
        for (int l = 0; l < 5; l++)
            if (!m[l])
                cur[l*8 +: 8] = d[l*8 +: 8];
        mem[key(b, col)] = cur;
        issue(sdpi_pkg::CMD_WRITE, b, col, m);
        idle(2);
    endtask

    task automatic rd(input int b, input int col, input logic [4:0] m);
        logic [39:0] exp;
        int k;
        exp = mem[key(b, col)];
        for (int l = 0; l < 5; l++)
            if (m[l])
                exp[l*8 +: 8] = 8'h00;
        issue(sdpi_pkg::CMD_READ, b, col, m);
        for (k = 0; k < 12 && rvalid_o !== 1'b1; k++)
        begin
            @(posedge core_clk_i);
            #1;
        end
        if (k == 12)
        begin
            n_mismatch++;
            stop_test();
        end
        check("read word", rdata_o, exp);
        idle(4);
    endtask

    // ------------------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------------------
    initial
    begin
        repeat (20000) @(posedge core_clk_i);
        n_mismatch++;
        stop_test();
    end

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        seed = $urandom(32'h5578);
        idle(12);
        rstn_i <= 1'b1;
        idle(2);
        check("mode reset", mode_o, 13'h0023);
        issue(sdpi_pkg::CMD_LOAD_MODE, 0, 13'h0020, 5'h00);
        idle(3);
        check("mode load", mode_o, 13'h0020);
        for (int b = 0; b < 4; b++)
        begin
            open_row[b] = $urandom_range(0, 8191);
            issue(sdpi_pkg::CMD_ACTIVATE, b, open_row[b], 5'h00);
        end
        idle(3);
        check("banks open", bank_open_o, 4'hF);
        $display("test mode and activate done");
        for (int i = 0; i < 8; i++)
        begin
            d = {8'($urandom), $urandom};
            wr(i % 4, i + (i > 3 ? 13'h0800 : 0), 5'h00);
            d = {8'($urandom), $urandom};
            wr(i % 4, i + (i > 3 ? 13'h0800 : 0), 5'($urandom_range(0, 31)));
            rd(i % 4, i, 5'h00);
            rd(i % 4, i, 5'($urandom_range(0, 30)));
        end
        issue(sdpi_pkg::CMD_LOAD_MODE, 0, 13'h0032, 5'h00);
        idle(3);
        rd(0, 0, 5'h00);
        issue(sdpi_pkg::CMD_READ, 0, 0, 5'h00);
        nb = 0;
        repeat (10)
        begin
            @(posedge core_clk_i);
            #1;
            if (rvalid_o === 1'b1)
                nb++;
        end
        check("burst beats", 40'(nb), 40'h4);
        issue(sdpi_pkg::CMD_LOAD_MODE, 0, 13'h0020, 5'h00);
        idle(3);
        $display("test masked data done");
        rd(2, 2 | 13'h0400, 5'h00);
        idle(2);
        check("auto precharge", bank_open_o, 4'hB);
        issue(sdpi_pkg::CMD_PRECHARGE, 1, 0, 5'h00);
        idle(3);
        check("precharge one", bank_open_o, 4'h9);
        issue(sdpi_pkg::CMD_PRECHARGE, 0, 13'h0400, 5'h00);
        idle(6);
        check("precharge all", bank_open_o, 4'h0);
        for (int c = 0; c < 8; c++)
            issue(4'(c) | 4'h8, 0, 13'h0027, 5'h00);
        idle(3);
        check("deselected mode", mode_o, 13'h0020);
        check("deselected bank", bank_open_o, 4'h0);
        $display("test precharge and select done");
        cke_i <= 1'b0;
        idle(5);
        check("precharge pd", pwr_state_o, sdpi_pkg::PWR_PRE_PD);
        issue(sdpi_pkg::CMD_ACTIVATE, 0, 0, 5'h00);
        idle(3);
        check("pd drops cmd", bank_open_o, 4'h0);
        cke_i <= 1'b1;
        idle(5);
        check("pd exit", pwr_state_o, sdpi_pkg::PWR_RUN);
        issue(sdpi_pkg::CMD_ACTIVATE, 0, 0, 5'h00);
        cke_i <= 1'b0;
        idle(5);
        check("active pd", pwr_state_o, sdpi_pkg::PWR_ACT_PD);
        cke_i <= 1'b1;
        idle(5);
        issue(sdpi_pkg::CMD_LOAD_MODE, 0, 13'h0027, 5'h00);
        issue(sdpi_pkg::CMD_READ, 0, 0, 5'h00);
        idle(3);
        cke_i <= 1'b0;
        idle(6);
        check("suspend", pwr_state_o, sdpi_pkg::PWR_SUSPEND);
        check("burst held", burst_active_o, 1'b1);
        cke_i <= 1'b1;
        idle(4);
        issue(sdpi_pkg::CMD_BURST_STOP, 0, 0, 5'h00);
        idle(6);
        check("burst stopped", burst_active_o, 1'b0);
        check("run again", pwr_state_o, sdpi_pkg::PWR_RUN);
        $display("test power done");
        stop_test();
    end
endmodule // tb_sdram_pin_command_interface
`default_nettype wire
